// ---- logic/cmc_pkg.sv ----
// Purpose: constants for the comparator control logic
// Assumes: classic Wishbone, 32-bit data, byte addresses
// Notes:   control word sits in the low byte of its bus word
package cmc_pkg;
	localparam logic [7:0] CMC_ADDR_CTRL    = 8'hF8;
	localparam logic [7:0] CMC_ADDR_MODE    = 8'hFC;
	localparam logic [7:0] CMC_ADDR_RSTSEL  = 8'hF4;
	localparam logic [7:0] CMC_CTRL_RESET   = 8'h00;
	localparam logic [1:0] CMC_MODE_RESET   = 2'h0;
	localparam int         CMC_BIT_EN       = 7;
	localparam int         CMC_BIT_STATE    = 6;
	localparam int         CMC_BIT_RISE     = 5;
	localparam int         CMC_BIT_FALL     = 4;
	localparam int         CMC_POS_LSB      = 2;
	localparam int         CMC_NEG_LSB      = 0;
	localparam int         CMC_SYNC_STAGES  = 2;

	typedef enum logic [1:0] {
		CMC_HYST_OFF  = 2'b00,
		CMC_HYST_5MV  = 2'b01,
		CMC_HYST_10MV = 2'b10,
		CMC_HYST_20MV = 2'b11
	} cmc_hyst_e;

	typedef enum logic [0:0] {
		CMC_BUS_IDLE = 1'b0,
		CMC_BUS_ACK  = 1'b1
	} cmc_bus_e;
endpackage

// ---- logic/cmc_sync.sv ----
// Purpose: two-flop synchroniser for the comparator result
// Assumes: first stage feeds only the second stage
// Notes:   output is the last stage of the chain
`timescale 1ns/1ns
`default_nettype none
module cmc_sync
	import cmc_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic async_i,
	output logic      sync_o
);
	logic [CMC_SYNC_STAGES-1:0] chain_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			chain_r <= '0;
		end else begin
			chain_r <= {chain_r[CMC_SYNC_STAGES-2:0], async_i};
		end
	end

	assign sync_o = chain_r[CMC_SYNC_STAGES-1];
endmodule
`default_nettype wire

// ---- logic/cmc_top.sv ----
// Purpose: control and status logic of the on-chip voltage comparator
// Assumes: classic Wishbone slave, single clock clk_i, sync reset rst_i
// Notes:
// Notes on behaviour
// - falling output edge sets fall flag
// - rising output edge sets rise flag
// - flags stay set until software clears
// - interrupt request on either edge
// - state bit reads current output, no side effects
// - enable bit powers comparator on or off
// - disabled comparator drives port outputs low
// - registered and raw port outputs offered
// - raw output needs no system clock
// - low four bits hold hysteresis selection
// - negative hysteresis: off, 5, 10, 20 mV
// - positive hysteresis chosen the same, independently
// - comparator output selectable as reset source
// - response time set by separate mode register
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module cmc_top
	import cmc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// analog core
	input  wire logic        cmp_result_i,
	output logic             cmp_power_o,
	output logic      [1:0]  pos_hyst_sel_o,
	output logic      [1:0]  neg_hyst_sel_o,
	output logic      [1:0]  response_mode_o,
	// port pins and system
	output logic             cmp_sync_out_o,
	output logic             cmp_raw_out_o,
	output logic             cmp_irq_o,
	output logic             cmp_reset_req_o
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	logic       cmp_enable_r;
	logic       rise_edge_flag_r;
	logic       fall_edge_flag_r;
	logic [1:0] pos_hyst_r;
	logic [1:0] neg_hyst_r;
	logic [1:0] response_mode_r;
	logic       reset_sel_r;
	logic       sample_prev_r;
	logic       sync_out_r;
	logic       irq_r;
	logic       reset_req_r;
	logic [31:0] rdata_r;
	cmc_bus_e   bus_r;
	cmc_bus_e   bus_nxt;

	// ----------------------------------------
	// synchroniser
	// ----------------------------------------
	wire cmp_gated = cmp_result_i & cmp_enable_r;
	logic cmp_sample;

	cmc_sync u_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i (cmp_gated),
		.sync_o  (cmp_sample)
	);

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire req       = wb_cyc_i & wb_stb_i & (bus_r == CMC_BUS_IDLE);
	wire hit_ctrl  = (wb_adr_i == CMC_ADDR_CTRL);
	wire hit_mode  = (wb_adr_i == CMC_ADDR_MODE);
	wire hit_rsel  = (wb_adr_i == CMC_ADDR_RSTSEL);
	wire wr_lane0  = req & wb_we_i & wb_sel_i[0];
	wire wr_ctrl   = wr_lane0 & hit_ctrl;
	wire wr_mode   = wr_lane0 & hit_mode;
	wire wr_rsel   = wr_lane0 & hit_rsel;
	// edges are seen once per sample pair, so each transition flags once
	wire rise_evt  = cmp_sample & ~sample_prev_r;
	wire fall_evt  = ~cmp_sample & sample_prev_r;

	// set beats a clear written in the same cycle
	wire rise_nxt  = rise_evt | (wr_ctrl ? wb_dat_i[CMC_BIT_RISE] : rise_edge_flag_r);
	wire fall_nxt  = fall_evt | (wr_ctrl ? wb_dat_i[CMC_BIT_FALL] : fall_edge_flag_r);

	// state bit is read-only; reading has no side effects
	wire [7:0] ctrl_view = {cmp_enable_r, cmp_sample & cmp_enable_r, rise_edge_flag_r, fall_edge_flag_r,
		pos_hyst_r, neg_hyst_r};
	wire [31:0] rd_mux = hit_ctrl ? {24'h000000, ctrl_view} :
		hit_mode ? {30'h00000000, response_mode_r} :
		hit_rsel ? {31'h00000000, reset_sel_r} : 32'h00000000;

	assign bus_nxt = req ? CMC_BUS_ACK : CMC_BUS_IDLE;

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_r   <= CMC_BUS_IDLE;
			rdata_r <= 32'h00000000;
		end else begin
			bus_r   <= bus_nxt;
			rdata_r <= req ? rd_mux : rdata_r;
		end
	end

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmp_enable_r <= CMC_CTRL_RESET[CMC_BIT_EN];
			pos_hyst_r   <= CMC_CTRL_RESET[CMC_POS_LSB+1:CMC_POS_LSB];
			neg_hyst_r   <= CMC_CTRL_RESET[CMC_NEG_LSB+1:CMC_NEG_LSB];
		end else if (wr_ctrl) begin
			cmp_enable_r <= wb_dat_i[CMC_BIT_EN];
			pos_hyst_r   <= wb_dat_i[CMC_POS_LSB+1:CMC_POS_LSB];
			neg_hyst_r   <= wb_dat_i[CMC_NEG_LSB+1:CMC_NEG_LSB];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			response_mode_r <= CMC_MODE_RESET;
			reset_sel_r     <= 1'b0;
		end else begin
			if (wr_mode) begin
				response_mode_r <= wb_dat_i[1:0];
			end
			if (wr_rsel) begin
				reset_sel_r <= wb_dat_i[0];
			end
		end
	end

	// ----------------------------------------
	// edge flags and outputs
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sample_prev_r    <= 1'b0;
			rise_edge_flag_r <= 1'b0;
			fall_edge_flag_r <= 1'b0;
			sync_out_r       <= 1'b0;
			irq_r            <= 1'b0;
			reset_req_r      <= 1'b0;
		end else begin
			sample_prev_r    <= cmp_sample;
			rise_edge_flag_r <= rise_nxt;
			fall_edge_flag_r <= fall_nxt;
			sync_out_r       <= cmp_sample & cmp_enable_r;
			irq_r            <= rise_nxt | fall_nxt;
			reset_req_r      <= reset_sel_r & cmp_enable_r & cmp_sample;
		end
	end

	// raw path is combinational so it works with the clock stopped
	assign cmp_raw_out_o   = cmp_gated;
	assign cmp_sync_out_o  = sync_out_r;
	assign cmp_power_o     = cmp_enable_r;
	assign pos_hyst_sel_o  = pos_hyst_r;
	assign neg_hyst_sel_o  = neg_hyst_r;
	assign response_mode_o = response_mode_r;
	assign cmp_irq_o       = irq_r;
	assign cmp_reset_req_o = reset_req_r;
	assign wb_ack_o        = (bus_r == CMC_BUS_ACK);
	assign wb_dat_o        = rdata_r;
endmodule
`default_nettype wire

// ---- dv/cmc_core_model.sv ----
// Purpose: analog comparator core model
// Assumes: level_i is the input sign
// Notes:   unpowered output wanders
`timescale 1ns/1ns
`default_nettype none
module cmc_core_model (
	input  wire logic clk_i,
	input  wire logic power_i,
	input  wire logic level_i,
	output logic      result_o
);
	// no supply: junk that changes every cycle
	assign result_o = power_i ? level_i : clk_i;
endmodule
`default_nettype wire

// ---- dv/cmc_top_sva.sv ----
// Purpose: port checker for cmc_top
// Assumes: one clock, sync reset
// Notes:   flag latencies per hand-over
`timescale 1ns/1ns
`default_nettype none
module cmc_top_sva (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic wb_ack_o,
	input wire logic cmp_result_i,
	input wire logic cmp_power_o,
	input wire logic cmp_sync_out_o,
	input wire logic cmp_raw_out_o,
	input wire logic cmp_irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	ack_resp_a: assert property (s_req |=> wb_ack_o) else $error("no ack");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
	raw_gate_a: assert property (cmp_raw_out_o == (cmp_result_i && cmp_power_o))
		else $error("raw output wrong");
	off_low_a: assert property (!cmp_power_o [*2] |-> !cmp_sync_out_o)
		else $error("pin high while off");
	sync_hi_a: assert property ((cmp_power_o && cmp_result_i) [*4] |-> cmp_sync_out_o)
		else $error("sync output stuck");
	rise_irq_a: assert property ($rose(cmp_sync_out_o) |-> ##[1:3] cmp_irq_o)
		else $error("rise not flagged");
	fall_irq_a: assert property ($fell(cmp_sync_out_o) |-> ##[1:3] cmp_irq_o)
		else $error("fall not flagged");
	irq_hold_a: assert property ($fell(cmp_irq_o) |-> $past(wb_we_i && wb_stb_i))
		else $error("flag cleared itself");
endmodule
bind cmc_top cmc_top_sva i_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o,
	.cmp_result_i, .cmp_power_o, .cmp_sync_out_o, .cmp_raw_out_o, .cmp_irq_o);
`default_nettype wire

// ---- dv/tb_top.sv ----
// Purpose: register-level test of cmc_top
// Assumes: classic Wishbone, ack after one cycle
// Notes:   outputs read a full edge after ack
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
	$display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
	import cmc_pkg::*;
	logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, level = 0;
	logic [7:0]  wb_adr_i = 0;
	logic [3:0]  wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 0, wb_dat_o, rd_data;
	logic        wb_ack_o, cmp_result_i, cmp_power_o, cmp_sync_out_o, cmp_raw_out_o, cmp_irq_o, cmp_reset_req_o;
	logic [1:0]  pos_hyst_sel_o, neg_hyst_sel_o, response_mode_o;
	int          fail_count = 0, n_compared = 0;
	cmc_top i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .cmp_result_i, .cmp_power_o, .pos_hyst_sel_o, .neg_hyst_sel_o,
		.response_mode_o, .cmp_sync_out_o, .cmp_raw_out_o, .cmp_irq_o, .cmp_reset_req_o);
	cmc_core_model i_core (.clk_i, .power_i(cmp_power_o), .level_i(level), .result_o(cmp_result_i));
	initial forever #10 clk_i = ~clk_i;
	task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, d};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd_data = wb_dat_o;
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		@(posedge clk_i);
	endtask
	task automatic finish_test;
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// ---------------------------------
	// watchdog, tests need under 100 cycles
	// ---------------------------------
	initial begin
		repeat (3000) @(posedge clk_i);
		fail_count++;
		finish_test;
	end
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 0;
		bus(0, CMC_ADDR_CTRL, 0);
		`CHK(rd_data, 32'h0);
		bus(1, 8'h10, 8'hFF);
		bus(0, 8'h10, 0);
		`CHK(rd_data, 32'h0);
		wb_sel_i <= 4'hE;
		bus(1, CMC_ADDR_CTRL, 8'h80);
		wb_sel_i <= 4'hF;
		bus(0, CMC_ADDR_CTRL, 0);
		`CHK(rd_data, 32'h0);
		for (int i = 0; i < 4; i++) begin
			bus(1, CMC_ADDR_CTRL, 8'h80 | 8'(i << 2) | 8'(3 - i));
			`CHK({cmp_power_o, pos_hyst_sel_o, neg_hyst_sel_o}, {1'b1, 2'(i), 2'(3 - i)});
		end
		bus(1, CMC_ADDR_MODE, 8'h02);
		`CHK(response_mode_o, 2'h2);
		bus(1, CMC_ADDR_CTRL, 8'h80);
		level <= 1;
		repeat (6) @(posedge clk_i);
		bus(0, CMC_ADDR_CTRL, 0);
		`CHK(rd_data, 32'hE0);
		bus(0, CMC_ADDR_CTRL, 0);
		`CHK(rd_data, 32'hE0);
		`CHK({cmp_irq_o, cmp_sync_out_o, cmp_raw_out_o}, 3'b111);
		bus(1, CMC_ADDR_RSTSEL, 8'h01);
		@(posedge clk_i);
		`CHK(cmp_reset_req_o, 1'b1);
		level <= 0;
		repeat (6) @(posedge clk_i);
		bus(0, CMC_ADDR_CTRL, 0);
		`CHK(rd_data, 32'hB0);
		bus(1, CMC_ADDR_CTRL, 8'h80);
		repeat (2) @(posedge clk_i);
		`CHK(cmp_irq_o, 1'b0);
		level <= 1;
		repeat (6) @(posedge clk_i);
		bus(1, CMC_ADDR_CTRL, 8'h00);
		@(posedge clk_i);
		`CHK({cmp_power_o, cmp_sync_out_o, cmp_raw_out_o}, 3'b000);
		finish_test;
	end
endmodule
`default_nettype wire
